// file: bench/reply_sink.sv
// Behavioural bus master that takes exception reply bytes and keeps them.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ns

module reply_sink (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Reply byte stream
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_last,
    output logic            tx_ready,
    // Behaviour
    input  wire logic       slow
);
    logic [7:0] got[$];

    initial tx_ready = 1'b0;

    // A slow master stalls at random, so every byte must be held until it is taken.
    always @(posedge clock) begin
        if (!rst && tx_valid && tx_ready) got.push_back(tx_byte);
        #1 tx_ready = slow ? 1'($urandom_range(0, 1)) : 1'b1;
    end
endmodule

// file: bench/serial_slave_status_exception_tb.sv
// Self-checking bench of the status-monitor and exception-response engine.
// Assumes the engine, its register header and the reply_sink model.
`timescale 1ns/1ns
`include "status_exception_regs.svh"
`define check_eq(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end

module serial_slave_status_exception_tb;
    logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, req_comm_error = 1'b0, rtu_mode = 1'b1;
    logic [7:0] req_slave = 8'h01, req_function = 8'h03, my_address = 8'h01, panel_lamps = 8'h00;
    logic [15:0] req_address = 16'h0000, req_count = 16'h0001, timeout_period_setting = 16'h0000;
    logic [1:0] comm_fault_action_setting = 2'h0;
    logic dev_fault = 1'b0, bus_activity = 1'b1, slow = 1'b0;
    logic freq_from_comm = 1'b0, freq_from_analog = 1'b0, op_from_comm = 1'b0;
    logic params_locked = 1'b0, drive_running = 1'b0, jog_active = 1'b0;
    logic [15:0] mon[13];
    logic req_ready, tx_valid, tx_last, tx_ready, rd_valid, rd_last, err_shown;
    logic [7:0] tx_byte, comm_error_display;
    logic [15:0] rd_addr, rd_word;
    logic [15:0] addrs[13] = '{16'h2101, 16'h2102, 16'h210A, 16'h210C, 16'h210D, 16'h210F,
        16'h2200, 16'h2201, 16'h2202, 16'h2203, 16'h2204, 16'h2205, 16'h2206};
    int mismatches = 0, num_checks = 0, cycles = 0;

    always #5 clock = ~clock;
    initial foreach (mon[i]) mon[i] = 16'h0000;

    status_exception_core #(.TIMEOUT_UNIT_CYCLES(10)) uut (.clock(clock), .rst(rst),
        .req_valid(req_valid), .req_comm_error(req_comm_error), .req_slave(req_slave),
        .req_function(req_function), .req_address(req_address), .req_count(req_count),
        .req_ready(req_ready), .my_address(my_address), .rtu_mode(rtu_mode),
        .dev_fault(dev_fault), .timeout_period_setting(timeout_period_setting),
        .comm_fault_action_setting(comm_fault_action_setting), .bus_activity(bus_activity),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready),
        .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_word(rd_word), .rd_last(rd_last),
        .panel_lamps(panel_lamps), .freq_from_comm(freq_from_comm),
        .freq_from_analog(freq_from_analog), .op_from_comm(op_from_comm),
        .params_locked(params_locked), .drive_running(drive_running),
        .jog_active(jog_active), .freq_command(mon[1]), .power_factor(mon[2]),
        .motor_speed(mon[3]), .encoder_pulse_high(mon[4]), .output_power(mon[5]),
        .feedback_pct(mon[6]), .user_low(mon[7]), .user_high(mon[8]),
        .voltage_analog_input(mon[9]), .current_analog_input(mon[10]),
        .aux_analog_input(mon[11]), .heatsink_temp(mon[12]),
        .err_shown(err_shown), .comm_error_display(comm_error_display));

    reply_sink sink (.clock(clock), .rst(rst), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow));

    // ********************************************************************
    // Expected values
    // ********************************************************************
    function automatic logic [15:0] exp_word(input int i);
        if (i == 0) return {2'b00, jog_active, drive_running, params_locked, op_from_comm,
            freq_from_analog, freq_from_comm, panel_lamps};
        return mon[i];
    endfunction

    function automatic logic [15:0] crc3(input logic [23:0] d);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < 3; i++) begin
            c ^= {8'h00, d[23 - 8 * i -: 8]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction

    // ********************************************************************
    // Tasks
    // ********************************************************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic send(input logic [7:0] s, f, input logic [15:0] a, n, input logic e);
        while (req_ready !== 1'b1) @(posedge clock) #1;
        {req_slave, req_function, req_address, req_count, req_comm_error} = {s, f, a, n, e};
        req_valid = 1'b1;
        @(posedge clock) #1 req_valid = 1'b0;
    endtask

    task automatic read_run(input int first, input int n);
        int k;
        k = 0;
        send(8'h01, 8'h03, addrs[first], 16'(n), 1'b0);
        repeat (n + 3) begin
            if (rd_valid === 1'b1) begin
                `check_eq(rd_addr, addrs[first + k])
                `check_eq(rd_word, exp_word(first + k))
                `check_eq(rd_last, (k == n - 1))
                k++;
            end
            @(posedge clock) #1;
        end
        `check_eq(k, n)
    endtask

    task automatic exc(input logic [7:0] f, input logic [15:0] a, n, input logic [7:0] code);
        logic [7:0] e[$];
        logic [15:0] c;
        c = crc3({8'h01, f | 8'h80, code});
        e = {8'h01, f | 8'h80, code};
        if (rtu_mode) e = {e, c[7:0], c[15:8]};
        else e.push_back(8'h00 - (8'h01 + (f | 8'h80) + code));
        sink.got.delete();
        send(8'h01, f, a, n, 1'b0);
        for (int i = 0; i < 200 && sink.got.size() < e.size(); i++) @(posedge clock) #1;
        `check_eq(sink.got.size(), e.size())
        foreach (e[i]) if (i < sink.got.size()) `check_eq(sink.got[i], e[i])
        `check_eq(comm_error_display, code)
        `check_eq(err_shown, 1'b1)
    endtask

    // ********************************************************************
    // Main sequence
    // ********************************************************************
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(43));
        repeat (5) @(posedge clock);
        #1 rst = 1'b0;
        `check_eq({req_ready, tx_valid, rd_valid, err_shown, comm_error_display}, 12'h800)
        foreach (addrs[m]) begin
            rtu_mode = m[0];
            slow = m[1];
            exc(8'h01, 16'h2101, 16'h0001, 8'h01);
        end
        rtu_mode = 1'b1;
        exc(8'h06, 16'h2101, 16'h0005, 8'h04);
        exc(8'h06, 16'h3000, 16'h0005, 8'h02);
        exc(8'h03, 16'h2103, 16'h0001, 8'h02);
        exc(8'h03, 16'h2200, 16'h0008, 8'h02);
        exc(8'h03, 16'h2200, 16'h0000, 8'h03);
        exc(8'h03, 16'h2200, 16'h0009, 8'h03);
        rtu_mode = 1'b0;
        exc(8'h2B, 16'h2206, 16'h0001, 8'h01);
        dev_fault = 1'b1;
        exc(8'h03, 16'h2206, 16'h0001, 8'h04);
        dev_fault = 1'b0;
        sink.got.delete();
        send(8'h01, 8'h2B, 16'h2101, 16'h0001, 1'b1);
        @(posedge clock) #1;
        send(8'h05, 8'h2B, 16'h2101, 16'h0001, 1'b0);
        repeat (20) @(posedge clock) #1;
        `check_eq(comm_error_display, 8'h04)
        // An absent reply is the master's failed transaction; here it is expected.
        `check_eq(sink.got.size(), 0)
        `check_eq(req_ready, 1'b1)
        repeat (4) begin
            {panel_lamps, freq_from_comm, freq_from_analog, op_from_comm} = $urandom;
            {params_locked, drive_running, jog_active} = $urandom;
            foreach (mon[i]) mon[i] = 16'($urandom);
            read_run(0, 2);
            read_run(2, 1);
            read_run(3, 2);
            read_run(5, 1);
            read_run(6, 7);
            read_run(12, 1);
        end
        `check_eq(err_shown, 1'b0)
        {bus_activity, timeout_period_setting, comm_fault_action_setting} = {1'b0, 16'h3, 2'h3};
        repeat (80) @(posedge clock) #1;
        `check_eq(err_shown, 1'b0)
        comm_fault_action_setting = 2'h2;
        for (int i = 0; i < 80 && err_shown !== 1'b1; i++) @(posedge clock) #1;
        `check_eq(err_shown, 1'b1)
        `check_eq(comm_error_display, 8'h10)
        end_of_test();
    end
endmodule

// file: rtl/frame_check_unit.sv
// Combinational frame check over the three bytes of an exception reply.
// Assumes bytes in transmit order: slave address, function, exception code.
`timescale 1ns/1ns
`include "status_exception_regs.svh"

module frame_check_unit (
    // Reply bytes
    input  wire logic [7:0]  byte0,
    input  wire logic [7:0]  byte1,
    input  wire logic [7:0]  byte2,
    // Check results
    output logic      [15:0] crc_value,
    output logic      [7:0]  lrc_value
);

    logic [23:0] stream;
    logic [7:0]  sum;

    assign stream = {byte2, byte1, byte0};
    assign sum    = 8'(byte0 + byte1 + byte2);

    // ********************************************************************
    // Sixteen-bit cyclic check, reflected, and longitudinal check
    // ********************************************************************
    always_comb begin
        logic [15:0] crc;
        crc = `CRC_SEED;
        for (int b = 0; b < 3; b++) begin
            crc = crc ^ {8'h00, stream[b*8 +: 8]};
            for (int k = 0; k < 8; k++) begin
                crc = crc[0] ? ((crc >> 1) ^ `CRC_POLY) : (crc >> 1);
            end
        end
        crc_value = crc;
    end

    // Two's complement of the byte sum.
    assign lrc_value = 8'(~sum + 8'h01);

endmodule

// file: rtl/status_exception_core.sv
// Status-monitor and exception-response engine of a drive's serial slave.
// Assumes an upstream frame receiver that delivers decoded requests and a
// downstream framer that wraps reply bytes (character coding, delimiters).
`timescale 1ns/1ns
`include "status_exception_regs.svh"

module status_exception_core #(
    parameter int unsigned TIMEOUT_UNIT_CYCLES = `TIMEOUT_UNIT_NS / `CLOCK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Decoded request
    input  wire logic        req_valid,
    input  wire logic        req_comm_error,
    input  wire logic [7:0]  req_slave,
    input  wire logic [7:0]  req_function,
    input  wire logic [15:0] req_address,
    input  wire logic [15:0] req_count,
    output logic             req_ready,
    // Configuration and health
    input  wire logic [7:0]  my_address,
    input  wire logic        rtu_mode,
    input  wire logic        dev_fault,
    input  wire logic [15:0] timeout_period_setting,
    input  wire logic [1:0]  comm_fault_action_setting,
    input  wire logic        bus_activity,
    // Exception reply bytes
    output logic             tx_valid,
    output logic [7:0]       tx_byte,
    output logic             tx_last,
    input  wire logic        tx_ready,
    // Read words for the normal-reply framer
    output logic             rd_valid,
    output logic [15:0]      rd_addr,
    output logic [15:0]      rd_word,
    output logic             rd_last,
    // Drive state
    input  wire logic [7:0]  panel_lamps,
    input  wire logic        freq_from_comm,
    input  wire logic        freq_from_analog,
    input  wire logic        op_from_comm,
    input  wire logic        params_locked,
    input  wire logic        drive_running,
    input  wire logic        jog_active,
    // Monitor values
    input  wire logic [15:0] freq_command,
    input  wire logic [15:0] power_factor,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] encoder_pulse_high,
    input  wire logic [15:0] output_power,
    input  wire logic [15:0] feedback_pct,
    input  wire logic [15:0] user_low,
    input  wire logic [15:0] user_high,
    input  wire logic [15:0] voltage_analog_input,
    input  wire logic [15:0] current_analog_input,
    input  wire logic [15:0] aux_analog_input,
    input  wire logic [15:0] heatsink_temp,
    // Keypad error indication
    output logic             err_shown,
    output logic [7:0]       comm_error_display
);

    status_exception_pkg::engine_state_type state_reg, state_next;
    logic [2:0]  idx_reg;
    logic [15:0] addr_reg, left_reg;
    logic [7:0]  func_reg, code_reg;
    logic        mode_reg;
    logic [23:0] tick_reg;
    logic [15:0] silence_reg;
    logic        timeout_hit_reg;

    // ********************************************************************
    // Map decode
    // ********************************************************************
    function automatic logic is_mapped(input logic [15:0] a);
        return (a == `ADDR_DRIVE_STATUS_FLAGS) || (a == `ADDR_FREQ_COMMAND_READBACK) ||
               (a == `ADDR_POWER_FACTOR_MONITOR) || (a == `ADDR_MOTOR_SPEED_RPM) ||
               (a == `ADDR_ENCODER_PULSE_HIGH) || (a == `ADDR_OUTPUT_POWER_KW) ||
               (a >= `ADDR_FEEDBACK_SIGNAL_PCT && a <= `ADDR_HEATSINK_TEMPERATURE);
    endfunction

    wire [15:0] status_word = {2'b00, jog_active, drive_running,
                               params_locked,
                               op_from_comm,
                               freq_from_analog,
                               freq_from_comm,
                               panel_lamps};

    // Pure selection: a read leaves the drive's values alone; a read started with no exception clears err_shown unless timeout_event comes in that cycle.
    wire [15:0] word_sel =
        (addr_reg == `ADDR_DRIVE_STATUS_FLAGS)    ? status_word :
        (addr_reg == `ADDR_FREQ_COMMAND_READBACK) ? freq_command :
        (addr_reg == `ADDR_POWER_FACTOR_MONITOR)  ? power_factor :
        (addr_reg == `ADDR_MOTOR_SPEED_RPM)       ? motor_speed :
        (addr_reg == `ADDR_ENCODER_PULSE_HIGH)    ? encoder_pulse_high :
        (addr_reg == `ADDR_OUTPUT_POWER_KW)       ? output_power :
        (addr_reg == `ADDR_FEEDBACK_SIGNAL_PCT)   ? feedback_pct :
        (addr_reg == `ADDR_USER_VALUE_LOW)        ? user_low :
        (addr_reg == `ADDR_USER_VALUE_HIGH)       ? user_high :
        (addr_reg == `ADDR_VOLTAGE_INPUT_PCT)     ? voltage_analog_input :
        (addr_reg == `ADDR_CURRENT_INPUT_PCT)     ? current_analog_input :
        (addr_reg == `ADDR_AUX_INPUT_PCT)         ? aux_analog_input :
        (addr_reg == `ADDR_HEATSINK_TEMPERATURE)  ? heatsink_temp :
                                                    16'h0000;

    // Every word of a block read must exist; words past the count pass.
    logic [7:0] word_ok;
    for (genvar i = 0; i < 8; i++) begin : g_span
        assign word_ok[i] = (16'(i) >= req_count) || is_mapped(16'(req_address + 16'(i)));
    end

    // ********************************************************************
    // Request classification
    // ********************************************************************
    wire accept_any  = req_valid && (state_reg == status_exception_pkg::ST_IDLE);
    wire addressed   = req_slave == my_address;
    // Frames received with errors are dropped with no reply.
    wire accept      = accept_any && !req_comm_error && addressed;
    wire is_read     = req_function == `FUNC_READ_WORDS;
    wire is_write    = req_function == `FUNC_WRITE_WORD;
    wire count_bad   = is_read && (req_count == 16'h0000 || req_count > `MAX_READ_WORDS);
    wire span_bad    = is_read ? (word_ok != 8'hFF) : !is_mapped(req_address);

    // Writes to an existing word cannot be carried out: every word is read-only.
    wire [7:0] code_w =
        (!is_read && !is_write) ? `EXC_ILLEGAL_FUNC :
        count_bad               ? `EXC_ILLEGAL_VALUE :
        span_bad                ? `EXC_ILLEGAL_ADDR :
        (is_write || dev_fault) ? `EXC_DEVICE_FAILURE :
                                  8'h00;
    wire start_exc   = accept && (code_w != 8'h00);
    wire start_read  = accept && (code_w == 8'h00);

    // ********************************************************************
    // Exception reply assembly
    // ********************************************************************
    wire [7:0]  flagged_func = req_function | `FUNC_EXCEPTION_FLAG;
    wire [7:0]  chk_func     = start_exc ? flagged_func : func_reg;
    wire [7:0]  chk_code     = start_exc ? code_w : code_reg;
    wire        chk_mode     = start_exc ? rtu_mode : mode_reg;
    wire [2:0]  load_idx     = start_exc ? 3'h0 : 3'(idx_reg + 3'h1);
    wire [2:0]  last_idx     = chk_mode ? `LAST_INDEX_RTU : `LAST_INDEX_ASCII;
    wire [15:0] crc_w;
    wire [7:0]  lrc_w;

    frame_check_unit u_check (
        .byte0     (my_address),
        .byte1     (chk_func),
        .byte2     (chk_code),
        .crc_value (crc_w),
        .lrc_value (lrc_w)
    );

    // CRC goes low byte first; ASCII mode carries one LRC byte.
    wire [7:0] byte_sel =
        (load_idx == 3'h0) ? my_address :
        (load_idx == 3'h1) ? chk_func :
        (load_idx == 3'h2) ? chk_code :
        (load_idx == 3'h3) ? (chk_mode ? crc_w[7:0] : lrc_w) :
                             crc_w[15:8];
    wire tx_step = tx_valid && tx_ready;
    wire tx_done = tx_step && tx_last;

    // ********************************************************************
    // Engine
    // ********************************************************************
    always_comb begin
        case (state_reg)
            status_exception_pkg::ST_IDLE:
                state_next = start_exc  ? status_exception_pkg::ST_EXC :
                             start_read ? status_exception_pkg::ST_READ : state_reg;
            status_exception_pkg::ST_READ:
                state_next = (left_reg == 16'h0001) ? status_exception_pkg::ST_IDLE : state_reg;
            status_exception_pkg::ST_EXC:
                state_next = tx_done ? status_exception_pkg::ST_IDLE : state_reg;
            default:
                state_next = status_exception_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= status_exception_pkg::ST_IDLE;
            req_ready <= 1'b1;
            idx_reg   <= 3'h0;
            func_reg  <= 8'h00;
            code_reg  <= 8'h00;
            mode_reg  <= 1'b0;
            addr_reg  <= 16'h0000;
            left_reg  <= 16'h0000;
        end else begin
            state_reg <= state_next;
            req_ready <= state_next == status_exception_pkg::ST_IDLE;
            if (start_exc) begin
                func_reg <= flagged_func;
                code_reg <= code_w;
                mode_reg <= rtu_mode;
            end
            if (start_exc || tx_step) begin
                idx_reg <= load_idx;
            end
            if (start_read) begin
                addr_reg <= req_address;
                left_reg <= req_count;
            end else if (state_reg == status_exception_pkg::ST_READ) begin
                addr_reg <= 16'(addr_reg + 16'h0001);
                left_reg <= 16'(left_reg - 16'h0001);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_valid <= 1'b0;
            tx_byte  <= 8'h00;
            tx_last  <= 1'b0;
        end else if (start_exc || (tx_step && !tx_last)) begin
            tx_valid <= 1'b1;
            tx_byte  <= byte_sel;
            tx_last  <= load_idx == last_idx;
        end else if (tx_done) begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_addr  <= 16'h0000;
            rd_word  <= 16'h0000;
            rd_last  <= 1'b0;
        end else begin
            rd_valid <= state_reg == status_exception_pkg::ST_READ;
            rd_addr  <= addr_reg;
            rd_word  <= word_sel;
            rd_last  <= (state_reg == status_exception_pkg::ST_READ) && (left_reg == 16'h0001);
        end
    end

    // ********************************************************************
    // Bus silence watchdog and keypad indication
    // ********************************************************************
    // A slow prescaler keeps the silence counter narrow; it restarts on every
    // activity, so detection comes within a cycle of the set number of units.
    wire timeout_armed = (timeout_period_setting != 16'h0000) &&
                         (comm_fault_action_setting <= 2'h2);
    wire tick          = tick_reg == 24'(TIMEOUT_UNIT_CYCLES - 1);
    wire timeout_event = timeout_armed && !timeout_hit_reg &&
                         (silence_reg >= timeout_period_setting) && !bus_activity;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick_reg        <= 24'h000000;
            silence_reg     <= 16'h0000;
            timeout_hit_reg <= 1'b0;
        end else if (bus_activity || !timeout_armed) begin
            tick_reg        <= 24'h000000;
            silence_reg     <= 16'h0000;
            timeout_hit_reg <= 1'b0;
        end else begin
            tick_reg <= tick ? 24'h000000 : 24'(tick_reg + 24'h000001);
            if (tick && silence_reg != 16'hFFFF) begin
                silence_reg <= 16'(silence_reg + 16'h0001);
            end
            if (timeout_event) begin
                timeout_hit_reg <= 1'b1;
            end
        end
    end

    // Codes up to 9 coincide in hex and two-digit decimal form.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            err_shown          <= 1'b0;
            comm_error_display <= 8'h00;
        end else if (timeout_event) begin
            err_shown          <= 1'b1;
            comm_error_display <= `EXC_TIMEOUT_DISPLAY;
        end else if (start_exc) begin
            err_shown          <= 1'b1;
            comm_error_display <= code_w;
        end else if (start_read) begin
            err_shown          <= 1'b0;
        end
    end

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_status_lamps: assert property (
        rd_valid && rd_addr == `ADDR_DRIVE_STATUS_FLAGS |-> rd_word[4:0] == $past(panel_lamps[4:0])
    ) else $error("status lamps mismatch");
    chk_status_source: assert property (
        rd_valid && rd_addr == `ADDR_DRIVE_STATUS_FLAGS |-> rd_word[11:8] ==
            $past({params_locked, op_from_comm, freq_from_analog, freq_from_comm})
    ) else $error("status source bits mismatch");
    chk_status_run: assert property (
        rd_valid && rd_addr == `ADDR_DRIVE_STATUS_FLAGS |->
            rd_word[15:12] == {2'b00, $past(jog_active), $past(drive_running)}
    ) else $error("status run bits mismatch");
    chk_monitor_words: assert property (
        rd_valid |-> (rd_addr != `ADDR_OUTPUT_POWER_KW || rd_word == $past(output_power)) &&
            (rd_addr != `ADDR_HEATSINK_TEMPERATURE || rd_word == $past(heatsink_temp))
    ) else $error("monitor word mismatch");
    chk_error_silent: assert property (
        accept_any && req_comm_error |=> req_ready && !tx_valid && !rd_valid
    ) else $error("reply after errored frame");
    chk_exc_function: assert property (
        start_exc |=> tx_valid && tx_byte == my_address &&
            func_reg == ($past(req_function) | 8'h80)
    ) else $error("exception function wrong");
    chk_exc_func_byte: assert property (
        tx_valid && idx_reg == 3'h1 |-> tx_byte == func_reg && tx_byte[7]
    ) else $error("exception function byte wrong");
    chk_exc_code: assert property (
        tx_valid && idx_reg == 3'h2 |-> tx_byte >= 8'h01 && tx_byte <= 8'h04 &&
            err_shown && comm_error_display == tx_byte
    ) else $error("exception code or display wrong");
    chk_exc_length: assert property (
        tx_valid && tx_last |-> idx_reg == (mode_reg ? 3'h4 : 3'h3)
    ) else $error("exception frame length wrong");
    chk_timeout_code: assert property (
        $rose(timeout_hit_reg) |-> err_shown && comm_error_display == 8'h10
    ) else $error("timeout code not shown");

endmodule

// file: rtl/status_exception_pkg.sv
// Types shared by the status-monitor and exception-response block.
// Assumes nothing of its surroundings.
package status_exception_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXC  = 2'b10
    } engine_state_type;

endpackage

// file: rtl/status_exception_regs.svh
// Register map, field positions, exception codes and timing figures of the
// status-monitor and exception-response block.
// Assumes inclusion by its bare name from any file that needs the map.
`ifndef STATUS_EXCEPTION_REGS_SVH
`define STATUS_EXCEPTION_REGS_SVH

// ********************************************************************
// Word addresses of the read-only map
// ********************************************************************
`define ADDR_DRIVE_STATUS_FLAGS     16'h2101
`define ADDR_FREQ_COMMAND_READBACK  16'h2102
`define ADDR_POWER_FACTOR_MONITOR   16'h210A
`define ADDR_MOTOR_SPEED_RPM        16'h210C
`define ADDR_ENCODER_PULSE_HIGH     16'h210D
`define ADDR_OUTPUT_POWER_KW        16'h210F
`define ADDR_FEEDBACK_SIGNAL_PCT    16'h2200
`define ADDR_USER_VALUE_LOW         16'h2201
`define ADDR_USER_VALUE_HIGH        16'h2202
`define ADDR_VOLTAGE_INPUT_PCT      16'h2203
`define ADDR_CURRENT_INPUT_PCT      16'h2204
`define ADDR_AUX_INPUT_PCT          16'h2205
`define ADDR_HEATSINK_TEMPERATURE   16'h2206

// ********************************************************************
// Status word field positions
// ********************************************************************
`define STAT_LAMPS_LSB      0
`define STAT_LAMPS_MSB      7
`define STAT_FREQ_COMM_BIT  8
`define STAT_FREQ_ANLG_BIT  9
`define STAT_OP_COMM_BIT    10
`define STAT_LOCKED_BIT     11
`define STAT_RUNNING_BIT    12
`define STAT_JOG_BIT        13

// ********************************************************************
// Function codes, exception codes and frame layout
// ********************************************************************
`define FUNC_READ_WORDS     8'h03
`define FUNC_WRITE_WORD     8'h06
`define FUNC_EXCEPTION_FLAG 8'h80
`define EXC_ILLEGAL_FUNC    8'h01
`define EXC_ILLEGAL_ADDR    8'h02
`define EXC_ILLEGAL_VALUE   8'h03
`define EXC_DEVICE_FAILURE  8'h04
`define EXC_TIMEOUT_DISPLAY 8'h10
`define MAX_READ_WORDS      16'h0008
`define LAST_INDEX_RTU      3'h4
`define LAST_INDEX_ASCII    3'h3
`define CRC_SEED            16'hFFFF
`define CRC_POLY            16'hA001

// ********************************************************************
// Timing
// ********************************************************************
`define CLOCK_PERIOD_NS     10
`define TIMEOUT_UNIT_NS     100000000

`endif
